// file: hw/dqm_pkg.sv
// Functional notes
// - sixteen region control registers, host written
// - region start index in bits 29:16
// - descriptor size code bits 11:8, 32<<code
// - region capacity code bits 2:0, 32<<code
// - sixty-four queues with own registers
// - push/pop write appends pointer and size
// - push/pop read removes and returns head
// - descriptor pointer lives in bits 31:5
// - empty queue read returns all zero
// - entry size code 4:0, 24+4*code bytes
// - optional read-only entry count per queue
// - entry count bits 13:0, rest zero
// - optional read-only byte total per queue
// - byte total bits 27:0, 31:28 zero
// - pending bit set on push, cleared on the pop that empties the queue
package dqm_pkg;
    // ---------------------------------------------
    // sizes
    // ---------------------------------------------
    localparam int NUM_REGIONS = 16;
    localparam int NUM_QUEUES = 64;
    localparam int CNT_W = 14; // entry count width
    localparam int BYTES_W = 28; // byte total width
    // ---------------------------------------------
    // byte offsets inside the block window
    // ---------------------------------------------
    localparam logic [3:0] GRP_REGION = 4'h0; // 0x000..0x03c
    localparam logic [3:0] GRP_PUSHPOP = 4'h1; // 0x100..0x1fc
    localparam logic [3:0] GRP_COUNT = 4'h2; // 0x200..0x2fc
    localparam logic [3:0] GRP_BYTES = 4'h3; // 0x300..0x3fc
    localparam logic [3:0] GRP_PEND = 4'h4; // 0x400 low, 0x404 high
    // ---------------------------------------------
    // fields and reset values
    // ---------------------------------------------
    localparam logic [27:0] BASE_BYTES = 28'h0000018; // size code 0
    localparam logic [31:0] REGION_RST = 32'h00000000;
    localparam logic RESP_OKAY = 1'b0;
    // region control layout, reserved bits dropped
    typedef struct packed {
        logic [13:0] startIdx;
        logic [3:0] descSizeCode;
        logic [2:0] capCode;
    } dqm_region_s;
    // one queue entry as pushed and popped
    typedef struct packed {
        logic [26:0] descriptorPointer;
        logic [4:0] descriptorSizeCode;
    } dqm_entry_s;
    // bus data phase sequencer, gray on each step except BUS_WDONE back to BUS_IDLE
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WCOMMIT = 2'b01,
        BUS_WDONE = 2'b11
    } dqm_bus_e;
    // register group decoded from an address
    typedef enum logic [2:0] {
        RK_NONE, RK_REGION, RK_PUSHPOP, RK_COUNT, RK_BYTES, RK_PEND
    } dqm_kind_e;
endpackage : dqm_pkg

// file: hw/dqm_top.sv
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module dqm_top #(
    parameter int NUM_ENTRIES = 64, // shared entry pool depth
    parameter logic [63:0] CNT_FEATURE = 64'hffffffffffffffff,
    parameter logic [63:0] BYTE_FEATURE = 64'hffffffffffffffff
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    // ---------------------------------------------
    // local sizes
    // ---------------------------------------------
    localparam int IW = $clog2(NUM_ENTRIES);
    localparam int NQ = dqm_pkg::NUM_QUEUES;
    localparam logic [IW:0] POOL_MAX = (IW+1)'(NUM_ENTRIES);

    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    // bytes held by one entry, from its size code
    function automatic logic [27:0] descBytes(input logic [4:0] code);
        return dqm_pkg::BASE_BYTES + {21'h0, code, 2'b00};
    endfunction : descBytes

    // which register group an address falls into
    function automatic dqm_pkg::dqm_kind_e kindOf(input logic [11:0] a);
        dqm_pkg::dqm_kind_e k;
        k = dqm_pkg::RK_NONE;
        case (a[11:8])
            dqm_pkg::GRP_REGION: begin
                if (a[7:6] == 2'b00) k = dqm_pkg::RK_REGION;
            end
            dqm_pkg::GRP_PUSHPOP: k = dqm_pkg::RK_PUSHPOP;
            dqm_pkg::GRP_COUNT: k = dqm_pkg::RK_COUNT;
            dqm_pkg::GRP_BYTES: k = dqm_pkg::RK_BYTES;
            dqm_pkg::GRP_PEND: begin
                if (a[7:3] == 5'h00) k = dqm_pkg::RK_PEND;
            end
            default: k = dqm_pkg::RK_NONE;
        endcase
        return k;
    endfunction : kindOf

    // ---------------------------------------------
    // state
    // ---------------------------------------------
    dqm_pkg::dqm_bus_e busState_q; // data phase sequencer
    dqm_pkg::dqm_kind_e dphKind_q; // group of the access in flight
    logic [5:0] dphIdx_q; // word index of the access in flight
    dqm_pkg::dqm_region_s regionQ [dqm_pkg::NUM_REGIONS];
    dqm_pkg::dqm_entry_s entryMem [NUM_ENTRIES]; // entry pool
    logic [IW-1:0] linkNext [NUM_ENTRIES]; // per-entry successor
    logic [IW-1:0] headQ [NQ]; // oldest entry per queue
    logic [IW-1:0] tailQ [NQ]; // newest entry per queue
    logic [NQ-1:0][dqm_pkg::CNT_W-1:0] cntQ; // entries per queue
    logic [NQ-1:0][dqm_pkg::BYTES_W-1:0] bytesQ; // bytes per queue
    logic [NQ-1:0] queuePendingBits_q; // nonempty flags
    logic [IW-1:0] freeHead_q; // top of recycled list
    logic [IW:0] freeCnt_q; // recycled entries available
    logic [IW:0] fresh_q; // never-used entries handed out
    logic [31:0] hrdata_q; // registered read data

    // ---------------------------------------------
    // address phase decode
    // ---------------------------------------------
    logic accept; // address phase taken this edge
    dqm_pkg::dqm_kind_e addrKind; // group of the offered address
    logic [5:0] popQ; // queue addressed by a read
    logic popReq; // read of a push/pop register
    logic popOk; // that read finds an entry
    logic [IW-1:0] popIdx; // entry leaving the queue
    logic pushReq; // write of a push/pop register commits
    logic pushOk; // push has room in the pool
    logic poolFull; // no entry left to hand out
    logic [IW-1:0] newIdx; // entry receiving a push
    logic regionWr; // region control write commits
    logic [27:0] pushBytes; // size of the entry being pushed

    // hsize is not decoded: every access counts as a word
    assign accept = hsel && hready && htrans[1];
    assign addrKind = kindOf(haddr[11:0]);
    assign popQ = haddr[7:2];
    assign popReq = accept && !hwrite && (addrKind == dqm_pkg::RK_PUSHPOP);
    assign popOk = popReq && (cntQ[popQ] != '0);
    assign popIdx = headQ[popQ];
    // writes land one cycle into their data phase, while hready is low
    assign pushReq = (busState_q == dqm_pkg::BUS_WCOMMIT)
        && (dphKind_q == dqm_pkg::RK_PUSHPOP);
    assign regionWr = (busState_q == dqm_pkg::BUS_WCOMMIT)
        && (dphKind_q == dqm_pkg::RK_REGION);
    assign poolFull = (freeCnt_q == '0) && (fresh_q == POOL_MAX);
    // a push into a full pool is dropped; software sees no count change
    assign pushOk = pushReq && !poolFull;
    assign newIdx = (freeCnt_q != '0) ? freeHead_q : fresh_q[IW-1:0];
    assign pushBytes = descBytes(hwdata[4:0]);

    // ---------------------------------------------
    // bus outputs
    // ---------------------------------------------
    // stalling the write data phase one cycle keeps a read that follows
    // from seeing counts before the write has landed
    assign hreadyout = (busState_q != dqm_pkg::BUS_WCOMMIT);
    assign hresp = dqm_pkg::RESP_OKAY;
    assign hrdata = hrdata_q;

    // data phase sequencer
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            busState_q <= dqm_pkg::BUS_IDLE;
        end else begin
            case (busState_q)
                dqm_pkg::BUS_IDLE, dqm_pkg::BUS_WDONE: begin
                    if (accept && hwrite) begin
                        busState_q <= dqm_pkg::BUS_WCOMMIT;
                    end else begin
                        busState_q <= dqm_pkg::BUS_IDLE;
                    end
                end
                dqm_pkg::BUS_WCOMMIT: busState_q <= dqm_pkg::BUS_WDONE;
                default: busState_q <= dqm_pkg::BUS_IDLE;
            endcase
        end
    end

    // address phase capture
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dphKind_q <= dqm_pkg::RK_NONE;
            dphIdx_q <= 6'h00;
        end else if (accept) begin
            dphKind_q <= addrKind;
            dphIdx_q <= haddr[7:2];
        end
    end

    // ---------------------------------------------
    // region control registers
    // ---------------------------------------------
    // reserved size codes are stored as written; the pool ignores them
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int r = 0; r < dqm_pkg::NUM_REGIONS; r++) begin
                regionQ[r] <= dqm_pkg::dqm_region_s'(dqm_pkg::REGION_RST);
            end
        end else if (regionWr) begin
            regionQ[dphIdx_q[3:0]].startIdx <= hwdata[29:16];
            regionQ[dphIdx_q[3:0]].descSizeCode <= hwdata[11:8];
            regionQ[dphIdx_q[3:0]].capCode <= hwdata[2:0];
        end
    end

    // ---------------------------------------------
    // entry pool and queue links
    // ---------------------------------------------
    // entry payload, pointer in 31:5 and size code in 4:0
    always_ff @(posedge mclk) begin
        if (pushOk) begin
            entryMem[newIdx] <= dqm_pkg::dqm_entry_s'(hwdata);
        end
    end

    // successor links: queue chain on push, free chain on pop
    always_ff @(posedge mclk) begin
        if (pushOk && (cntQ[dphIdx_q] != '0)) begin
            linkNext[tailQ[dphIdx_q]] <= newIdx;
        end else if (popOk) begin
            linkNext[popIdx] <= freeHead_q;
        end
    end

    // head and tail per queue; stale when the count is zero
    always_ff @(posedge mclk) begin
        if (pushOk) begin
            tailQ[dphIdx_q] <= newIdx;
            if (cntQ[dphIdx_q] == '0) begin
                headQ[dphIdx_q] <= newIdx;
            end
        end
        if (popOk) begin
            headQ[popQ] <= linkNext[popIdx];
        end
    end

    // free entry accounting; push and pop never share a cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            freeHead_q <= '0;
            freeCnt_q <= '0;
            fresh_q <= '0;
        end else if (pushOk) begin
            if (freeCnt_q != '0) begin
                freeHead_q <= linkNext[freeHead_q];
                freeCnt_q <= freeCnt_q - 1'b1;
            end else begin
                fresh_q <= fresh_q + 1'b1;
            end
        end else if (popOk) begin
            freeHead_q <= popIdx;
            freeCnt_q <= freeCnt_q + 1'b1;
        end
    end

    // ---------------------------------------------
    // per-queue counters and pending flags
    // ---------------------------------------------
    for (genvar g = 0; g < NQ; g++) begin : gen_queue
        // counts move on the very edge that changes the contents
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                cntQ[g] <= '0;
                bytesQ[g] <= '0;
                queuePendingBits_q[g] <= 1'b0;
            end else if (pushOk && (dphIdx_q == 6'(g))) begin
                cntQ[g] <= cntQ[g] + 1'b1;
                bytesQ[g] <= bytesQ[g] + pushBytes;
                queuePendingBits_q[g] <= 1'b1;
            end else if (popOk && (popQ == 6'(g))) begin
                cntQ[g] <= cntQ[g] - 1'b1;
                bytesQ[g] <= bytesQ[g] - descBytes(entryMem[popIdx].descriptorSizeCode);
                queuePendingBits_q[g] <= (cntQ[g] != 14'h0001);
            end
        end
    end

    // ---------------------------------------------
    // read data
    // ---------------------------------------------
    // sampled at the address phase so reads take no wait state
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hrdata_q <= 32'h00000000;
        end else if (accept && !hwrite) begin
            case (addrKind)
                dqm_pkg::RK_REGION: begin
                    hrdata_q <= {2'b00, regionQ[popQ[3:0]].startIdx, 4'h0,
                        regionQ[popQ[3:0]].descSizeCode, 5'h00,
                        regionQ[popQ[3:0]].capCode};
                end
                dqm_pkg::RK_PUSHPOP: begin
                    // empty queue answers with a zero pointer and size
                    hrdata_q <= popOk ? 32'(entryMem[popIdx]) : 32'h00000000;
                end
                dqm_pkg::RK_COUNT: begin
                    // absent counters read as zero
                    hrdata_q <= CNT_FEATURE[popQ] ? {18'h00000, cntQ[popQ]}
                        : 32'h00000000;
                end
                dqm_pkg::RK_BYTES: begin
                    hrdata_q <= BYTE_FEATURE[popQ] ? {4'h0, bytesQ[popQ]}
                        : 32'h00000000;
                end
                dqm_pkg::RK_PEND: begin
                    hrdata_q <= haddr[2] ? queuePendingBits_q[63:32]
                        : queuePendingBits_q[31:0];
                end
                default: hrdata_q <= 32'h00000000;
            endcase
        end
    end

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    logic [13:0] selCnt; // count of the queue in flight
    logic [13:0] selPopCnt; // count of the queue being read
    logic [27:0] selBytes; // byte total of the queue in flight
    logic [31:0] headWord; // entry a pop will return
    assign selCnt = cntQ[dphIdx_q];
    assign selPopCnt = cntQ[popQ];
    assign selBytes = bytesQ[dphIdx_q];
    assign headWord = entryMem[popIdx];

    pushCount_a: assert property (@(posedge mclk) disable iff (!rst_n)
        pushOk |=> selCnt == $past(selCnt) + 1) else $error("push count wrong");
    popCount_a: assert property (@(posedge mclk) disable iff (!rst_n)
        popOk |=> selCnt == $past(selPopCnt) - 1) else $error("pop count wrong");
    popData_a: assert property (@(posedge mclk) disable iff (!rst_n)
        popOk |=> hrdata == $past(headWord)) else $error("pop data wrong");
    emptyPop_a: assert property (@(posedge mclk) disable iff (!rst_n)
        popReq && !popOk |=> hrdata == 32'h0) else $error("empty pop nonzero");
    pendMatch_a: assert property (@(posedge mclk) disable iff (!rst_n)
        queuePendingBits_q[dphIdx_q] == (selCnt != 14'h0)) else $error("pending flag wrong");
    byteAdd_a: assert property (@(posedge mclk) disable iff (!rst_n)
        pushOk |=> selBytes == $past(selBytes) + $past(pushBytes)) else $error("byte sum wrong");
    regionRsv_a: assert property (@(posedge mclk) disable iff (!rst_n)
        accept && !hwrite && addrKind == dqm_pkg::RK_REGION
        |=> hrdata[31:30] == 2'h0 && hrdata[15:12] == 4'h0 && hrdata[7:3] == 5'h0)
        else $error("region reserved bits set");
    regionWr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        regionWr |=> regionQ[dphIdx_q[3:0]].descSizeCode == $past(hwdata[11:8]))
        else $error("region size not stored");
    bytesRsv_a: assert property (@(posedge mclk) disable iff (!rst_n)
        accept && !hwrite && addrKind == dqm_pkg::RK_BYTES |=> hrdata[31:28] == 4'h0)
        else $error("byte total high bits set");
    cntRsv_a: assert property (@(posedge mclk) disable iff (!rst_n)
        accept && !hwrite && addrKind == dqm_pkg::RK_COUNT |=> hrdata[31:14] == 18'h0)
        else $error("count high bits set");
    wrStall_a: assert property (@(posedge mclk) disable iff (!rst_n)
        accept && hwrite |=> !hreadyout ##1 hreadyout) else $error("write stall not one cycle");
endmodule : dqm_top

// file: verif/dqm_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// bus master standing in for host software and dma channels
// ---------------------------------------------
module dqm_host_model (
    input wire logic mclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    logic [31:0] seenData; // read data as it stood at the sampling edge

    // idle bus from time zero so nothing is taken during reset
    initial begin
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h00000000;
    end

    // ---------------------------------------------
    // phase pacing
    // ---------------------------------------------
    // hready is looked at just before the edge, so the edge itself never races the slave
    task automatic waitReady();
        @(negedge mclk);
        while (hready !== 1'b1) begin
            @(negedge mclk);
        end
        seenData = hrdata;
        @(posedge mclk);
    endtask : waitReady

    // address phase of one whole-word transfer
    task automatic addrPhase(input logic [31:0] addr, input logic wr);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        waitReady();
        htrans <= 2'b00;
        hsel <= 1'b0;
        haddr <= ~addr; // stale address must not be mistaken for a live one
    endtask : addrPhase

    task automatic busWrite(input logic [31:0] addr, input logic [31:0] data);
        addrPhase(addr, 1'b1);
        hwdata <= data;
        waitReady();
        hwdata <= ~data; // released data no longer shows the last value
    endtask : busWrite

    task automatic busRead(input logic [31:0] addr, output logic [31:0] data);
        addrPhase(addr, 1'b0);
        waitReady();
        data = seenData;
    endtask : busRead
endmodule : dqm_host_model

// file: verif/dqm_top_tb.sv
`timescale 1ns/1ps
module dqm_top_tb;
    localparam int POOL = 8; // small pool so that refusal is reachable
    logic mclk;
    logic rst_n;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    int nFail = 0;
    int nCompared = 0;
    int cycles = 0;
    logic [31:0] ent [3] = '{32'hffffffe0, 32'h0000003f, 32'h12345663};
    logic [31:0] rem;

    // queue 5 lacks entry counting, queue 6 lacks byte totals
    dqm_top #(.NUM_ENTRIES(POOL), .CNT_FEATURE(64'hffffffffffffffdf),
        .BYTE_FEATURE(64'hffffffffffffffbf)) i_dqm_top (.mclk(mclk), .rst_n(rst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp));
    dqm_host_model i_dqm_host_model (.mclk(mclk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));

    // ---------------------------------------------
    // clock, reset and hang guard
    // ---------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // a lost handshake ends the run here instead of hanging
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            nFail++;
            endSim();
        end
    end

    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    function automatic logic [31:0] qa(input logic [3:0] grp, input logic [5:0] idx);
        return {20'h00000, grp, idx, 2'b00};
    endfunction : qa
    // bytes one entry adds: 24 plus 4 per code step
    function automatic logic [31:0] esize(input logic [31:0] e);
        return 32'h00000018 + {25'h0000000, e[4:0], 2'b00};
    endfunction : esize
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nFail++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rdChk(input logic [31:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        i_dqm_host_model.busRead(addr, d);
        check(d, exp);
    endtask : rdChk
    task automatic wr(input logic [31:0] addr, input logic [31:0] d);
        i_dqm_host_model.busWrite(addr, d);
    endtask : wr
    task automatic endSim();
        $display("compared %0d, mismatches %0d", nCompared, nFail);
        if (nFail == 0 && nCompared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : endSim

    // ---------------------------------------------
    // test sequence
    // ---------------------------------------------
    initial begin
        rst_n = 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        // everything starts cleared
        rdChk(qa(dqm_pkg::GRP_REGION, 6'h0f), 32'h00000000);
        rdChk(qa(dqm_pkg::GRP_COUNT, 6'h00), 32'h00000000);
        rdChk(qa(dqm_pkg::GRP_PEND, 6'h00), 32'h00000000);
        rdChk(qa(dqm_pkg::GRP_PUSHPOP, 6'h00), 32'h00000000);
        // every size code, reserved ones too, and all reserved bits set
        for (int r = 0; r < 16; r++) begin
            wr(qa(dqm_pkg::GRP_REGION, 6'(r)),
                {2'b11, 10'h2a5, 4'(r), 4'hf, 4'(r), 5'h1f, 3'(r)});
        end
        for (int r = 0; r < 16; r++) begin
            rdChk(qa(dqm_pkg::GRP_REGION, 6'(r)),
                {2'b00, 10'h2a5, 4'(r), 4'h0, 4'(r), 5'h00, 3'(r)});
        end
        // back-to-back pushes, then counts, pending and fifo order
        for (int i = 0; i < 3; i++) begin
            wr(qa(dqm_pkg::GRP_PUSHPOP, 6'h07), ent[i]);
        end
        rdChk(qa(dqm_pkg::GRP_COUNT, 6'h07), 32'h00000003);
        rdChk(qa(dqm_pkg::GRP_BYTES, 6'h07), 32'h000000d0);
        rdChk(qa(dqm_pkg::GRP_PEND, 6'h00), 32'h00000080);
        rem = 32'h000000d0;
        for (int i = 0; i < 3; i++) begin
            rdChk(qa(dqm_pkg::GRP_PUSHPOP, 6'h07), ent[i]);
            rem = rem - esize(ent[i]);
            rdChk(qa(dqm_pkg::GRP_COUNT, 6'h07), 32'(2 - i));
            rdChk(qa(dqm_pkg::GRP_BYTES, 6'h07), rem);
        end
        rdChk(qa(dqm_pkg::GRP_PUSHPOP, 6'h07), 32'h00000000);
        rdChk(qa(dqm_pkg::GRP_PEND, 6'h00), 32'h00000000);
        // last queue lands in the upper pending word
        wr(qa(dqm_pkg::GRP_PUSHPOP, 6'h3f), 32'hdeadbee5);
        rdChk(qa(dqm_pkg::GRP_PEND, 6'h01), 32'h80000000);
        rdChk(qa(dqm_pkg::GRP_PUSHPOP, 6'h3f), 32'hdeadbee5);
        rdChk(qa(dqm_pkg::GRP_PEND, 6'h01), 32'h00000000);
        // one push past a full pool is dropped
        rem = 32'h00000000;
        for (int i = 0; i <= POOL; i++) begin
            wr(qa(dqm_pkg::GRP_PUSHPOP, 6'h01), 32'h10000000 + 32'(i * 33));
            if (i < POOL) begin
                rem = rem + esize(32'(i * 33));
            end
        end
        rdChk(qa(dqm_pkg::GRP_COUNT, 6'h01), 32'(POOL));
        rdChk(qa(dqm_pkg::GRP_BYTES, 6'h01), rem);
        for (int i = 0; i <= POOL; i++) begin
            rdChk(qa(dqm_pkg::GRP_PUSHPOP, 6'h01),
                (i < POOL) ? 32'h10000000 + 32'(i * 33) : 32'h00000000);
        end
        // queues without the optional count or total read zero there
        wr(qa(dqm_pkg::GRP_PUSHPOP, 6'h05), 32'h00000040);
        wr(qa(dqm_pkg::GRP_PUSHPOP, 6'h06), 32'h00000041);
        rdChk(qa(dqm_pkg::GRP_COUNT, 6'h05), 32'h00000000);
        rdChk(qa(dqm_pkg::GRP_BYTES, 6'h05), 32'h00000018);
        rdChk(qa(dqm_pkg::GRP_COUNT, 6'h06), 32'h00000001);
        rdChk(qa(dqm_pkg::GRP_BYTES, 6'h06), 32'h00000000);
        rdChk(qa(dqm_pkg::GRP_PUSHPOP, 6'h05), 32'h00000040);
        rdChk(qa(dqm_pkg::GRP_PUSHPOP, 6'h06), 32'h00000041);
        // read-only count ignores writes; unmapped space reads zero
        wr(qa(dqm_pkg::GRP_COUNT, 6'h02), 32'hffffffff);
        rdChk(qa(dqm_pkg::GRP_COUNT, 6'h02), 32'h00000000);
        rdChk(32'h00000800, 32'h00000000);
        check({31'h00000000, hresp}, 32'h00000000);
        // mid-run reset drops queued entries and clears region settings
        wr(qa(dqm_pkg::GRP_PUSHPOP, 6'h02), 32'h00000080);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rdChk(qa(dqm_pkg::GRP_COUNT, 6'h02), 32'h00000000);
        rdChk(qa(dqm_pkg::GRP_PEND, 6'h00), 32'h00000000);
        rdChk(qa(dqm_pkg::GRP_REGION, 6'h03), 32'h00000000);
        rdChk(qa(dqm_pkg::GRP_PUSHPOP, 6'h02), 32'h00000000);
        // the pool hands out entries again after reset
        wr(qa(dqm_pkg::GRP_PUSHPOP, 6'h02), 32'h00000081);
        rdChk(qa(dqm_pkg::GRP_COUNT, 6'h02), 32'h00000001);
        rdChk(qa(dqm_pkg::GRP_PUSHPOP, 6'h02), 32'h00000081);
        endSim();
    end
endmodule : dqm_top_tb
